// >>> rtl/shc_map.vh
// Register map, field codes and timing counts of the steering homing block.
`ifndef SHC_MAP_VH
`define SHC_MAP_VH
`define SHC_A_ENC2_SWAP    24'h34eb00
`define SHC_A_AC_SEL       24'h34ed00
`define SHC_A_CTR_OFS      24'h34ee00
`define SHC_A_IN_ARR       24'h378600
`define SHC_A_TRIG_SEL     24'h378800
`define SHC_A_HOME_SPEED   24'h378900
`define SHC_A_METHOD       24'h378a00
`define SHC_A_TIMEOUT      24'h378b00
`define SHC_A_HOME_COMP    24'h378c00
`define SHC_A_STATUS       24'h379000
`define SHC_A_POSITION     24'h379100
`define SHC_A_RECAL_EN     24'h4e6700
`define SHC_ARR_SINGLE_NO  8'h00
`define SHC_ARR_NO_NC      8'h01
`define SHC_ARR_TWO_NO     8'h02
`define SHC_M_LEFT_POS     8'h00
`define SHC_M_RIGHT_POS    8'h01
`define SHC_M_RIGHT_NEG    8'h02
`define SHC_M_LEFT_NEG     8'h03
`define SHC_M_CENTER_POS   8'h04
`define SHC_RST_BYTE       8'h00
`define SHC_RST_WORD       16'h0000
`define SHC_RST_TIMEOUT    16'h00c8
`define SHC_TICK_NS        100000000
`define SHC_CLK_NS         5
`define SHC_TICK_CYC       (`SHC_TICK_NS / `SHC_CLK_NS)
`define SHC_ST_HOMED       0
`define SHC_ST_FAULT       1
`define SHC_ST_ACTIVE      2
`define SHC_ST_PAUSED      3
`define SHC_ST_DIR         4
`endif

// >>> rtl/shc_quad.v
// Quadrature decoder with a selectable counting sense and a loadable count.
`timescale 1ns/100ps
`default_nettype none
module shc_quad (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        swap_i,
	input  wire        clear_i,
	input  wire        load_i,
	input  wire [31:0] load_val_i,
	input  wire        a_i,
	input  wire        b_i,
	output reg  [31:0] count_o
);
	reg        a_reg;
	reg        b_reg;
	reg  [1:0] step_next;
	wire       moved;
	wire       fwd;
	assign moved = (a_i ^ a_reg) ^ (b_i ^ b_reg);
	assign fwd   = (a_reg ^ b_i) ^ swap_i;
	always @* begin
		step_next = 2'b00;
		if (moved) begin
			step_next = fwd ? 2'b01 : 2'b11;
		end
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			a_reg   <= 1'b0;
			b_reg   <= 1'b0;
			count_o <= 32'h00000000;
		end else begin
			a_reg <= a_i;
			b_reg <= b_i;
			if (clear_i) begin
				count_o <= 32'h00000000;
			end else if (load_i) begin
				count_o <= load_val_i;
			end else begin
				count_o <= count_o + {{30{step_next[1]}}, step_next};
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/shc_timer.v
// Tenth-of-a-second tick counter used for the homing time limit.
`timescale 1ns/100ps
`default_nettype none
module shc_timer #(
	parameter TICK_CYC = 32'd20000000
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        clear_i,
	input  wire        run_i,
	output reg  [15:0] tenths_o
);
	reg [31:0] div_reg;
	always @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			div_reg  <= 32'h00000000;
			tenths_o <= 16'h0000;
		end else if (run_i) begin
			if (div_reg == TICK_CYC - 32'd1) begin
				div_reg <= 32'h00000000;
				if (tenths_o != 16'hffff) begin
					tenths_o <= tenths_o + 16'h0001;
				end
			end else begin
				div_reg <= div_reg + 32'h00000001;
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/shc_top.v
// Steering homing and centering block with a classic Wishbone register slave.
//
// Contract
// - Encoder two swap set to 1 inverts its counting sense.
// - Auto center after homing; with selection 1 also at every interlock.
// - Zero position equals found home plus signed 16-bit center offset.
// - Absolute moves, auto center included, are referenced to the zero position.
// - With recalibration on, encoder count is reset to home at the switch edge.
// - With recalibration off, count error stays until keyswitch cycles.
// - Arrangement 0 single NO, 1 NO plus NC contacts, 2 two NO switches.
// - Trigger 0 homes at keyswitch on, 1 at first interlock.
// - Interlock-triggered homing pauses while interlock is off, then resumes.
// - Method codes 0 to 4 select the five switch and side choices.
// - Methods 0 and 1 start left when switch is on, right when off.
// - Home is left of the edge in method 0, right in method 1.
// - Methods 2 and 3 start right when switch is on, left when off.
// - Home is right of the edge in method 2, left in method 3.
// - Method 4 starts in the direction saved at the last shutdown.
// - Method 4 homes at the edge using one encoder and one switch.
// - Homing longer than the time limit raises a home-not-found fault.
// - Homing drives the motor at the programmed homing speed.
// - Homing compensation is added only under method 4.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "shc_map.vh"
module shc_top #(
	parameter TICK_CYC = `SHC_TICK_CYC
) (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [23:0] wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	input  wire        keyswitch_input_i,
	input  wire        interlock_i,
	input  wire        home_sw_a_i,
	input  wire        home_sw_b_i,
	input  wire        enc_a_i,
	input  wire        enc_b_i,
	input  wire        saved_dir_right_i,
	input  wire [31:0] move_target_i,
	output reg  [31:0] move_abs_o,
	output reg  [31:0] position_o,
	output reg         motor_run_o,
	output reg         motor_right_o,
	output reg  [15:0] motor_speed_o,
	output reg         center_go_o,
	output reg         homed_o,
	output reg         home_fault_o,
	output reg         save_dir_we_o,
	output reg         save_dir_right_o
);
	localparam S_IDLE  = 4'b0001;
	localparam S_SEEK  = 4'b0010;
	localparam S_HOMED = 4'b0100;
	localparam S_FAULT = 4'b1000;
	////////////////////////////////////////////////////////////////////////////
	reg  [7:0]  enc2_swap_reg;
	reg  [7:0]  ac_sel_reg;
	reg  [15:0] ctr_ofs_reg;
	reg  [7:0]  in_arr_reg;
	reg  [7:0]  trig_sel_reg;
	reg  [15:0] home_speed_reg;
	reg  [7:0]  method_reg;
	reg  [15:0] timeout_reg;
	reg  [15:0] home_comp_reg;
	reg  [7:0]  recal_en_reg;
	reg  [3:0]  state_reg;
	reg  [3:0]  state_next;
	reg         key_reg;
	reg         ilk_reg;
	reg         sw_reg;
	reg         sw_next;
	reg         sw_start_reg;
	reg         armed_reg;
	reg         dir_reg;
	reg         last_dir_reg;
	reg  [31:0] home_pos_reg;
	reg  [31:0] zero_pos_reg;
	reg  [31:0] home_next;
	reg  [31:0] rd_next;
	wire [31:0] count;
	wire [15:0] tenths;
	wire        key_rise;
	wire        key_fall;
	wire        ilk_rise;
	wire        paused;
	wire        sw_edge;
	wire        start;
	wire        dir_start;
	wire        wb_req;
	wire        wr;
	wire        recal;
	wire [31:0] ofs_ext;
	wire [31:0] comp_ext;
	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, ack dropped the cycle after it was given.
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// A write lands at the edge where the master samples ack, never one edge earlier.
	assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	always @* begin
		rd_next = 32'h00000000;
		case (wb_adr_i)
			`SHC_A_ENC2_SWAP:  rd_next = {24'h000000, enc2_swap_reg};
			`SHC_A_AC_SEL:     rd_next = {24'h000000, ac_sel_reg};
			`SHC_A_CTR_OFS:    rd_next = {16'h0000, ctr_ofs_reg};
			`SHC_A_IN_ARR:     rd_next = {24'h000000, in_arr_reg};
			`SHC_A_TRIG_SEL:   rd_next = {24'h000000, trig_sel_reg};
			`SHC_A_HOME_SPEED: rd_next = {16'h0000, home_speed_reg};
			`SHC_A_METHOD:     rd_next = {24'h000000, method_reg};
			`SHC_A_TIMEOUT:    rd_next = {16'h0000, timeout_reg};
			`SHC_A_HOME_COMP:  rd_next = {16'h0000, home_comp_reg};
			`SHC_A_RECAL_EN:   rd_next = {24'h000000, recal_en_reg};
			`SHC_A_STATUS:     rd_next = {27'h0000000, dir_reg, paused,
				state_reg[1], state_reg[3], state_reg[2]};
			`SHC_A_POSITION:   rd_next = position_o;
			default:           rd_next = 32'h00000000;
		endcase
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? rd_next : 32'h00000000;
		end
	end
	// Byte enables are honoured per lane; the status and position words are read only.
	always @(posedge clk_i) begin
		if (rst_i) begin
			enc2_swap_reg  <= `SHC_RST_BYTE;
			ac_sel_reg     <= `SHC_RST_BYTE;
			ctr_ofs_reg    <= `SHC_RST_WORD;
			in_arr_reg     <= `SHC_RST_BYTE;
			trig_sel_reg   <= `SHC_RST_BYTE;
			home_speed_reg <= `SHC_RST_WORD;
			method_reg     <= `SHC_RST_BYTE;
			timeout_reg    <= `SHC_RST_TIMEOUT;
			home_comp_reg  <= `SHC_RST_WORD;
			recal_en_reg   <= `SHC_RST_BYTE;
		end else if (wr) begin
			case (wb_adr_i)
				`SHC_A_ENC2_SWAP: if (wb_sel_i[0]) enc2_swap_reg <= wb_dat_i[7:0];
				`SHC_A_AC_SEL:    if (wb_sel_i[0]) ac_sel_reg <= wb_dat_i[7:0];
				`SHC_A_IN_ARR:    if (wb_sel_i[0]) in_arr_reg <= wb_dat_i[7:0];
				`SHC_A_TRIG_SEL:  if (wb_sel_i[0]) trig_sel_reg <= wb_dat_i[7:0];
				`SHC_A_METHOD:    if (wb_sel_i[0]) method_reg <= wb_dat_i[7:0];
				`SHC_A_RECAL_EN:  if (wb_sel_i[0]) recal_en_reg <= wb_dat_i[7:0];
				`SHC_A_CTR_OFS: begin
					if (wb_sel_i[0]) ctr_ofs_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) ctr_ofs_reg[15:8] <= wb_dat_i[15:8];
				end
				`SHC_A_HOME_SPEED: begin
					if (wb_sel_i[0]) home_speed_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) home_speed_reg[15:8] <= wb_dat_i[15:8];
				end
				`SHC_A_TIMEOUT: begin
					if (wb_sel_i[0]) timeout_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) timeout_reg[15:8] <= wb_dat_i[15:8];
				end
				`SHC_A_HOME_COMP: begin
					if (wb_sel_i[0]) home_comp_reg[7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1]) home_comp_reg[15:8] <= wb_dat_i[15:8];
				end
				default: begin
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Home switch decode and input edges.
	always @* begin
		sw_next = home_sw_a_i;
		if (method_reg == `SHC_M_CENTER_POS) begin
			sw_next = home_sw_a_i;
		end else if (in_arr_reg == `SHC_ARR_NO_NC) begin
			sw_next = home_sw_a_i & ~home_sw_b_i;
		end else if (in_arr_reg == `SHC_ARR_TWO_NO) begin
			sw_next = home_sw_a_i & home_sw_b_i;
		end
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			key_reg <= 1'b0;
			ilk_reg <= 1'b0;
			sw_reg  <= 1'b0;
		end else begin
			key_reg <= keyswitch_input_i;
			ilk_reg <= interlock_i;
			sw_reg  <= sw_next;
		end
	end
	assign key_rise = keyswitch_input_i & ~key_reg;
	assign key_fall = ~keyswitch_input_i & key_reg;
	assign ilk_rise = interlock_i & ~ilk_reg;
	// Method 4 waits for reaching the switch; the others wait to leave the start level.
	assign sw_edge  = (method_reg == `SHC_M_CENTER_POS) ? (sw_next & ~sw_reg)
		: (sw_next != sw_reg) && (sw_reg == sw_start_reg);
	assign paused   = (trig_sel_reg != 8'h00) & ~interlock_i;
	assign start    = (trig_sel_reg == 8'h00) ? key_rise
		: (armed_reg & ilk_rise);
	// Decided before the first drive cycle, so that run and direction rise together.
	assign dir_start = (method_reg == `SHC_M_CENTER_POS) ? saved_dir_right_i
		: method_reg[1] ? sw_next
		: ~sw_next;
	////////////////////////////////////////////////////////////////////////////
	// Encoder count; a keyswitch cycle is the only clear when recalibration is off.
	assign recal = (state_reg == S_HOMED) & (recal_en_reg != 8'h00) & sw_edge;
	shc_quad u_quad (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.swap_i     (enc2_swap_reg[0]),
		.clear_i    (key_rise),
		.load_i     (recal),
		.load_val_i (home_pos_reg),
		.a_i        (enc_a_i),
		.b_i        (enc_b_i),
		.count_o    (count)
	);
	// Time stands still while homing is paused, so a pause cannot cause a fault.
	shc_timer #(
		.TICK_CYC (TICK_CYC)
	) u_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (state_reg != S_SEEK),
		.run_i    (~paused),
		.tenths_o (tenths)
	);
	////////////////////////////////////////////////////////////////////////////
	// Home position from the transition point and the method.
	assign ofs_ext  = {{16{ctr_ofs_reg[15]}}, ctr_ofs_reg};
	assign comp_ext = {{16{home_comp_reg[15]}}, home_comp_reg};
	always @* begin
		home_next = count;
		case (method_reg)
			`SHC_M_LEFT_POS:   home_next = count - 32'h00000001;
			`SHC_M_RIGHT_POS:  home_next = count + 32'h00000001;
			`SHC_M_RIGHT_NEG:  home_next = count + 32'h00000001;
			`SHC_M_LEFT_NEG:   home_next = count - 32'h00000001;
			`SHC_M_CENTER_POS: home_next = count + comp_ext;
			default:           home_next = count;
		endcase
	end
	always @* begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: begin
				if (start) begin
					state_next = S_SEEK;
				end
			end
			S_SEEK: begin
				if (key_fall) begin
					state_next = S_IDLE;
				end else if (sw_edge && !paused) begin
					state_next = S_HOMED;
				end else if (tenths > timeout_reg) begin
					state_next = S_FAULT;
				end
			end
			S_HOMED: begin
				if (key_fall) begin
					state_next = S_IDLE;
				end
			end
			S_FAULT: begin
				if (key_fall) begin
					state_next = S_IDLE;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg    <= S_IDLE;
			sw_start_reg <= 1'b0;
			armed_reg    <= 1'b0;
			dir_reg      <= 1'b0;
			home_pos_reg <= 32'h00000000;
			zero_pos_reg <= 32'h00000000;
		end else begin
			state_reg <= state_next;
			if (key_rise) begin
				armed_reg <= 1'b1;
			end else if (key_fall || ilk_rise) begin
				armed_reg <= 1'b0;
			end
			if (state_reg == S_IDLE && start) begin
				sw_start_reg <= sw_next;
				dir_reg      <= dir_start;
			end
			if (state_reg == S_SEEK && state_next == S_HOMED) begin
				home_pos_reg <= home_next;
				zero_pos_reg <= home_next + ofs_ext;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Outputs toward the motor, the position loop and the parameter store.
	always @(posedge clk_i) begin
		if (rst_i) begin
			motor_run_o      <= 1'b0;
			motor_right_o    <= 1'b0;
			motor_speed_o    <= 16'h0000;
			center_go_o      <= 1'b0;
			homed_o          <= 1'b0;
			home_fault_o     <= 1'b0;
			move_abs_o       <= 32'h00000000;
			position_o       <= 32'h00000000;
			last_dir_reg     <= 1'b0;
			save_dir_we_o    <= 1'b0;
			save_dir_right_o <= 1'b0;
		end else begin
			motor_run_o   <= (state_next == S_SEEK) & ~paused;
			motor_right_o <= (state_reg == S_IDLE && start) ? dir_start : dir_reg;
			motor_speed_o <= (state_next == S_SEEK) ? home_speed_reg : 16'h0000;
			center_go_o   <= ((state_reg == S_SEEK) && (state_next == S_HOMED)) ||
				((state_reg == S_HOMED) && (ac_sel_reg != 8'h00) && ilk_rise);
			homed_o       <= (state_next == S_HOMED);
			home_fault_o  <= (state_next == S_FAULT);
			move_abs_o    <= zero_pos_reg + move_target_i;
			position_o    <= count - zero_pos_reg;
			if (motor_run_o) begin
				last_dir_reg <= motor_right_o;
			end
			save_dir_we_o    <= key_fall;
			save_dir_right_o <= motor_run_o ? motor_right_o : last_dir_reg;
		end
	end
endmodule
`default_nettype wire

// >>> tb/shc_wheel.sv
// Behavioural steered wheel with quadrature encoder and home switch contacts.
`timescale 1ns/100ps
`default_nettype none
module shc_wheel (
	input  wire logic       clk_i,
	input  wire logic       run_i,
	input  wire logic       right_i,
	input  wire logic [2:0] kind_i,
	input  wire logic [1:0] arr_i,
	output logic            enc_a_o,
	output logic            enc_b_o,
	output logic            sw_a_o,
	output logic            sw_b_o,
	output int              pos_o
);
	logic [1:0] ph = 2'h0;
	logic [2:0] dv = 3'h0;
	logic       on;
	initial pos_o = 0;
	// A step every eight cycles lets the drive stop before the next step lands.
	always @(posedge clk_i) begin
		dv <= dv + 3'h1;
		if (run_i && dv == 3'h0) begin
			pos_o <= right_i ? pos_o + 1 : pos_o - 1;
			ph <= right_i ? ph + 2'h1 : ph - 2'h1;
		end
	end
	// The switch sits at position 0.
	always_comb begin
		case (kind_i)
			3'h0: on = pos_o > 0;
			3'h1: on = pos_o < 0;
			default: on = pos_o >= 0 && pos_o < 3;
		endcase
	end
	assign enc_a_o = ph[1];
	assign enc_b_o = ph[1] ^ ph[0];
	assign sw_a_o = on;
	// An unused second contact toggles so that a stale level cannot pass for a match.
	assign sw_b_o = (arr_i == 2'h1) ? !on : (arr_i == 2'h2) ? on : dv[0];
endmodule
`default_nettype wire

// >>> tb/shc_top_props.sv
// Concurrent checks on the ports of the steering homing block.
`timescale 1ns/100ps
`default_nettype none
`include "shc_map.vh"
module shc_top_props #(
	parameter TICK_CYC = 10
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [23:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        keyswitch_input_i,
	input wire logic        interlock_i,
	input wire logic        home_sw_a_i,
	input wire logic [31:0] move_target_i,
	input wire logic [31:0] move_abs_o,
	input wire logic        motor_run_o,
	input wire logic        motor_right_o,
	input wire logic        center_go_o,
	input wire logic        homed_o,
	input wire logic        home_fault_o,
	input wire logic        save_dir_we_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic       wr;
	logic       trig_q;
	logic [7:0] meth_q;
	// Shadow copies of two selectors, kept from the bus writes.
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_q <= 1'b0;
			meth_q <= 8'h00;
		end else if (wr) begin
			if (wb_adr_i == `SHC_A_TRIG_SEL)
				trig_q <= |wb_dat_i[7:0];
			if (wb_adr_i == `SHC_A_METHOD)
				meth_q <= wb_dat_i[7:0];
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_found;
		$rose(homed_o);
	endsequence
	chk_ack_once: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack is not one pulse after the request");
	chk_found_center: assert property (s_found |-> center_go_o && !motor_run_o)
		else $error("home found without center request and stop");
	chk_center_pulse: assert property (center_go_o |=> !center_go_o)
		else $error("center request longer than one cycle");
	chk_pause_drive: assert property (trig_q && !interlock_i |=> !motor_run_o)
		else $error("drive on while interlock is off");
	chk_start_dir: assert property ($rose(motor_run_o) && meth_q < 8'h04 |->
		motor_right_o == (home_sw_a_i ^ (meth_q < 8'h02)))
		else $error("homing started in the wrong direction");
	chk_key_off: assert property (!keyswitch_input_i |=> !motor_run_o && !homed_o)
		else $error("drive or homed left on with keyswitch off");
	chk_save_dir: assert property ($fell(keyswitch_input_i) |=> save_dir_we_o ##1 !save_dir_we_o)
		else $error("direction not stored once at shutdown");
	chk_fault_idle: assert property (home_fault_o |-> !motor_run_o && !homed_o)
		else $error("drive or homed on with home fault");
	chk_abs_ref: assert property (homed_o [*3] |-> move_abs_o - $past(move_abs_o) ==
		$past(move_target_i) - $past(move_target_i, 2))
		else $error("absolute move does not follow target from a fixed zero");
endmodule
bind shc_top shc_top_props #(.TICK_CYC(TICK_CYC)) chk_u (.*);
`default_nettype wire

// >>> tb/steer_homing_centering_tb.sv
// Self-checking bench for the steering homing block.
`timescale 1ns/100ps
`default_nettype none
`include "shc_map.vh"
module steer_homing_centering_tb;
	logic        clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [23:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, move_target_i, move_abs_o, position_o, tgt;
	logic        keyswitch_input_i, interlock_i, home_sw_a_i, home_sw_b_i, enc_a_i, enc_b_i;
	logic        saved_dir_right_i, motor_run_o, motor_right_o, center_go_o, homed_o;
	logic        home_fault_o, save_dir_we_o, save_dir_right_o;
	logic [15:0] motor_speed_o;
	logic [2:0]  kind = 3'h0, hs = 3'h0;
	logic [1:0]  arr = 2'h0;
	logic [31:0] exp_q[$], pq[$], mq[$];
	int          n_fail = 0, checks_done = 0;
	localparam logic [23:0] REGS [7] = '{`SHC_A_ENC2_SWAP, `SHC_A_AC_SEL, `SHC_A_CTR_OFS,
		`SHC_A_IN_ARR, `SHC_A_TRIG_SEL, `SHC_A_METHOD, `SHC_A_RECAL_EN};
	shc_top #(.TICK_CYC(10)) dut_u (.*);
	shc_wheel wheel_u (.clk_i(clk_i), .run_i(motor_run_o), .right_i(motor_right_o),
		.kind_i(kind), .arr_i(arr), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i),
		.sw_a_o(home_sw_a_i), .sw_b_o(home_sw_b_i), .pos_o());
	always #2.5 clk_i = ~clk_i;
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	// The request holds until ack is sampled high; the bench timeout ends a hang.
	task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [23:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	always @(posedge clk_i) begin
		hs <= {hs[1:0], homed_o};
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			chk("read data", exp_q.pop_front(), wb_dat_o);
		if (hs[1:0] == 2'b01)
			chk("position", pq.pop_front(), position_o);
		if (hs[2:1] == 2'b01)
			chk("absolute move", mq.pop_front(), move_abs_o);
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		close_out();
	end
	initial begin
		int m, n, side, start, stop, ofs, d, sg, spd, sdir, mv;
		logic [31:0] v;
		{wb_cyc_i, wb_stb_i, wb_we_i, keyswitch_input_i, interlock_i} = 5'h00;
		{wb_adr_i, wb_dat_i, move_target_i} = '0;
		wb_sel_i = 4'hf;
		saved_dir_right_i = 1'b0;
		rst_i = 1'b1;
		void'($urandom(96));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`SHC_A_TIMEOUT, 32'h00c8);
		rd(24'h000100, 32'h0);
		for (int i = 0; i < 7; i++) begin
			rd(REGS[i], 32'h0);
			v = $urandom() & ((i == 2) ? 32'hffff : 32'hff);
			bus(1'b1, REGS[i], v);
			rd(REGS[i], v);
			bus(1'b1, REGS[i], 32'h0);
		end
		for (m = 0; m < 5; m++) begin
			sdir = $urandom_range(1, 0);
			side = (m == 0) ? 0 : (m == 4) ? 1 - sdir : $urandom_range(1, 0);
			sg = (m == 0) ? -1 : 1;
			ofs = $urandom_range(600, 0) - 300;
			spd = $urandom_range(32767, 1);
			d = (m == 0 || m == 3) ? -1 : (m == 4) ? 0 : 1;
			start = side ? $urandom_range(20, 6) : -$urandom_range(20, 6);
			stop = (m < 2) ? !side : (m < 4) ? -side : 2 * side;
			tgt = $urandom();
			bus(1'b1, `SHC_A_ENC2_SWAP, (m == 0));
			bus(1'b1, `SHC_A_METHOD, m);
			bus(1'b1, `SHC_A_IN_ARR, m % 3);
			bus(1'b1, `SHC_A_CTR_OFS, ofs & 32'hffff);
			bus(1'b1, `SHC_A_HOME_SPEED, spd);
			bus(1'b1, `SHC_A_RECAL_EN, (m >= 2));
			kind <= (m < 2) ? 3'h0 : (m < 4) ? 3'h1 : 3'h2;
			arr <= 2'(m % 3);
			saved_dir_right_i <= sdir[0];
			move_target_i <= tgt;
			wheel_u.pos_o <= start;
			mv = side ? -1 : 1;
			pq.push_back(sg * mv - d - ofs);
			mq.push_back(sg * (stop - mv - start) + d + ofs + tgt);
			@(posedge clk_i);
			keyswitch_input_i <= 1'b1;
			for (n = 0; n < 20 && motor_run_o !== 1'b1; n++) @(posedge clk_i);
			chk("speed", spd, motor_speed_o);
			if (m == 0) begin
				for (n = 0; n < 300 && wheel_u.pos_o != start + 4; n++) @(posedge clk_i);
				repeat (4) @(posedge clk_i);
				chk("count sense", -4, position_o);
			end
			for (n = 0; n < 3000 && homed_o !== 1'b1; n++) @(posedge clk_i);
			repeat (4) @(posedge clk_i);
			wheel_u.pos_o <= stop - mv;
			repeat (2) @(posedge clk_i);
			wheel_u.pos_o <= stop;
			repeat (4) @(posedge clk_i);
			chk("recalibration", (m >= 2) ? -ofs : sg * mv - d - ofs, position_o);
			keyswitch_input_i <= 1'b0;
			repeat (3) @(posedge clk_i);
			chk("stored direction", side == 0, save_dir_right_o);
		end
		bus(1'b1, `SHC_A_TRIG_SEL, 1);
		bus(1'b1, `SHC_A_AC_SEL, 1);
		bus(1'b1, `SHC_A_METHOD, 0);
		kind <= 3'h0;
		wheel_u.pos_o <= -10;
		pq.push_back(2 - ofs);
		mq.push_back(9 + ofs + tgt);
		keyswitch_input_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		chk("drive before interlock", 0, motor_run_o);
		interlock_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		interlock_i <= 1'b0;
		repeat (30) @(posedge clk_i);
		interlock_i <= 1'b1;
		for (n = 0; n < 3000 && homed_o !== 1'b1; n++) @(posedge clk_i);
		repeat (4) @(posedge clk_i);
		interlock_i <= 1'b0;
		@(posedge clk_i);
		interlock_i <= 1'b1;
		for (n = 0; n < 6 && center_go_o !== 1'b1; n++) @(posedge clk_i);
		chk("center request", 1, center_go_o);
		keyswitch_input_i <= 1'b0;
		bus(1'b1, `SHC_A_TRIG_SEL, 0);
		bus(1'b1, `SHC_A_TIMEOUT, 2);
		wheel_u.pos_o <= -200;
		keyswitch_input_i <= 1'b1;
		for (n = 0; n < 100 && home_fault_o !== 1'b1; n++) @(posedge clk_i);
		chk("time limit", 1, n > 25 && n < 60);
		keyswitch_input_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("unanswered", 0, pq.size() + mq.size());
		close_out();
	end
endmodule
`default_nettype wire
